// >>> core/mpt_mac_time.sv
// mac network-time counter, alarm and error status with register port
// assumed: one clock, events are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module mpt_mac_time
	import mpt_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// register port
	input  wire logic [7:0]       regAddr,
	input  wire logic [31:0]      regWrData,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [31:0]      regRdData,
	// time sharing between instances
	input  wire mpt_time_s        peerTime,
	output mpt_time_s             ownTime,
	output mpt_time_s             currentTime,
	// mac datapath events
	input  wire mpt_err_s         errEvents,
	// mac datapath controls
	output logic                  acceptShortFrames,
	output logic                  acceptOversizeFrames,
	output logic                  acceptErroredFrames,
	output logic      [1:0]       transmitFifoThreshold,
	output logic      [1:0]       receiveFifoThreshold,
	output logic                  rxHalted,
	output logic                  receiveStartDemand,
	// transmit interrupt line
	output logic                  txIrq
);
	logic [31:0]      ctl;
	logic [31:0]      incr;
	logic [31:0]      addend;
	logic [31:0]      offSec;
	logic [31:0]      offSub;
	logic [31:0]      almSec;
	logic [31:0]      almSub;
	logic [31:0]      cmd;
	logic [31:0]      ien;
	logic [31:0]      sta;
	logic [31:0]      fft;
	logic [31:0]      secLatch;
	logic             updBusy;
	logic             updGo;
	logic             offsetDone;
	logic             alarmFired;
	logic             alarmHit;
	logic             alarmReached;
	logic             run;
	logic [31:0]      setBits;
	logic [31:0]      next_rdData;
	mpt_time_s        coreTime;

	// write and sub-second read decode helpers
	logic             wrCtl;
	logic             wrSec;
	logic             wrSub;
	logic             wrAlm;
	logic             rdSub;
	logic             wrSta;
	logic             wrRsdr;

	assign wrCtl = regWr && (regAddr == OFS_CTL);
	assign wrSec = regWr && (regAddr == OFS_SEC);
	assign wrSub = regWr && (regAddr == OFS_SUB);
	assign wrAlm = regWr
		&& ((regAddr == OFS_ALMSEC) || (regAddr == OFS_ALMSUB));
	assign rdSub = regRd && (regAddr == OFS_SUB);
	assign wrSta = regWr && (regAddr == OFS_STA);
	assign wrRsdr = regWr && (regAddr == OFS_RSDR);

	// counting needs both the circuit enable and the start bit
	assign run = ctl[CTL_ENABLE] && ctl[CTL_START];

	// one offset request per trigger write
	assign updGo = ctl[CTL_UPDATE] && !updBusy && ctl[CTL_ENABLE];

	// own counter
	mpt_time_core u_core
	(
		.ref_clk     (ref_clk),
		.rst         (rst),
		.run         (run),
		.fine        (ctl[CTL_FINE]),
		.incr        (incr),
		.addend      (addend),
		.loadSec     (wrSec),
		.loadSub     (wrSub),
		.loadData    (regWrData),
		.applyOffset (updGo),
		.offSec      (offSec),
		.offSub      (offSub),
		.now         (coreTime),
		.offsetDone  (offsetDone)
	);

	// registered copy of the own counter for the peer instance
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ownTime <= '0;
		else
			ownTime <= coreTime;
	end

	// registered view of the selected time source
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			currentTime <= '0;
		else
			currentTime <= cmd[CMD_SHARE] ? peerTime : coreTime;
	end

	// timestamp control, update trigger clears itself when done
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctl <= RST_ZERO;
		else
		begin
			if (wrCtl)
				ctl <= (regWrData & CTL_MASK)
					| (ctl & (32'h00000001 << CTL_UPDATE));
			if (offsetDone)
				ctl[CTL_UPDATE] <= 1'b0;
			if (wrCtl && regWrData[CTL_UPDATE])
				ctl[CTL_UPDATE] <= 1'b1;                        // new trigger wins
		end
	end

	// offset handshake, busy from request until the core reports done
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			updBusy <= 1'b0;
		else if (updGo)
			updBusy <= 1'b1;
		else if (offsetDone)
			updBusy <= 1'b0;
	end

	// plain configuration registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			incr   <= RST_ZERO;
			addend <= RST_ZERO;
			offSec <= RST_ZERO;
			offSub <= RST_ZERO;
			almSec <= RST_ZERO;
			almSub <= RST_ZERO;
			cmd    <= RST_ZERO;
			ien    <= RST_ZERO;
			fft    <= RST_ZERO;
		end
		else if (regWr)
		begin
			case (regAddr)
				OFS_INC:    incr   <= regWrData;
				OFS_ADDEND: addend <= regWrData;
				OFS_UPDSEC: offSec <= regWrData;
				OFS_UPDSUB: offSub <= regWrData;
				OFS_ALMSEC: almSec <= regWrData;
				OFS_ALMSUB: almSub <= regWrData;
				OFS_CMD:    cmd    <= regWrData & CMD_MASK;
				OFS_IEN:    ien    <= regWrData & IEN_MASK;
				OFS_FFT:    fft    <= regWrData & FFT_MASK;
				default:    ;
			endcase
		end
	end

	// seconds caught at the sub-second read
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			secLatch <= RST_ZERO;
		else if (rdSub)
			secLatch <= currentTime.sec;
	end

	// selected time at or past the programmed alarm
	assign alarmReached = {currentTime.sec, currentTime.sub}
		>= {almSec, almSub[SUB_W-1:0]};

	// alarm compare on the selected time, once per arming
	assign alarmHit = ctl[CTL_ALARM] && !alarmFired
		&& alarmReached;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			alarmFired <= 1'b0;
		else if (!ctl[CTL_ALARM] || wrAlm)
			alarmFired <= 1'b0;                                 // rearm
		else if (alarmHit)
			alarmFired <= 1'b1;
	end

	// status events this cycle
	always_comb
	begin
		setBits            = RST_ZERO;
		setBits[ST_ALARM]  = alarmHit;
		setBits[ST_TXBUS]  = errEvents.txBusFault;
		setBits[ST_RXBUS]  = errEvents.rxBusFault;
		setBits[ST_TDU]    = errEvents.txDescExhausted;
		setBits[ST_TRANSMIT_ABORTED]  = errEvents.txAborted;
		setBits[ST_TRANSMIT_FIFO_UNAVAILABLE]  = errEvents.txFifoUnavailable;
		setBits[ST_RDU]    = errEvents.rxDescExhausted;
		setBits[ST_SHORT]  = errEvents.shortFrame
			&& cmd[CMD_ARP];
		setBits[ST_LONG]   = errEvents.oversizeFrame
			&& cmd[CMD_ALP];
		setBits[ST_RECEIVE_FIFO_OVERFLOW]   = errEvents.rxFifoOverflow;
		setBits[ST_ALIGN]  = errEvents.alignmentFault;
		setBits[ST_CRC]    = errEvents.checksumFault;
	end

	// sticky status per bit, write one clears, a new event wins
	for (genvar b = 0; b < 32; b++)
	begin : g_sta
		always_ff @(posedge ref_clk or posedge rst)
		begin
			if (rst)
				sta[b] <= 1'b0;
			else if (setBits[b])
				sta[b] <= 1'b1;
			else if (wrSta && regWrData[b])
				sta[b] <= 1'b0;
		end
	end

	// alarm onto the transmit interrupt line
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			txIrq <= 1'b0;
		else
			txIrq <= sta[ST_ALARM] && ien[ST_ALARM];
	end

	// receive halt until software demands a restart
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rxHalted           <= 1'b0;
			receiveStartDemand <= 1'b0;
		end
		else
		begin
			receiveStartDemand <= wrRsdr;
			if (errEvents.rxDescExhausted)
				rxHalted <= 1'b1;
			else if (wrRsdr)
				rxHalted <= 1'b0;
		end
	end

	// datapath controls straight from the registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			acceptShortFrames     <= 1'b0;
			acceptOversizeFrames  <= 1'b0;
			acceptErroredFrames   <= 1'b0;
			transmitFifoThreshold <= 2'h0;
			receiveFifoThreshold  <= 2'h0;
		end
		else
		begin
			acceptShortFrames     <= cmd[CMD_ARP];
			acceptOversizeFrames  <= cmd[CMD_ALP];
			acceptErroredFrames   <= cmd[CMD_AEP];
			transmitFifoThreshold <= fft[FFT_TX_LO +: 2];
			receiveFifoThreshold  <= fft[FFT_RX_LO +: 2];
		end
	end

	// read mux, unmapped offsets read zero
	always_comb
	begin
		next_rdData = RST_ZERO;
		case (regAddr)
			OFS_CTL:    next_rdData = ctl;
			OFS_INC:    next_rdData = incr;
			OFS_ADDEND: next_rdData = addend;
			OFS_SEC:    next_rdData = secLatch;
			OFS_SUB:    next_rdData = {1'b0, currentTime.sub};
			OFS_UPDSEC: next_rdData = offSec;
			OFS_UPDSUB: next_rdData = offSub;
			OFS_ALMSEC: next_rdData = almSec;
			OFS_ALMSUB: next_rdData = almSub;
			OFS_CMD:    next_rdData = cmd;
			OFS_IEN:    next_rdData = ien;
			OFS_STA:    next_rdData = sta;
			OFS_FFT:    next_rdData = fft;
			default:    next_rdData = RST_ZERO;
		endcase
	end

	// read data stand for one cycle only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			regRdData <= RST_ZERO;
		else if (regRd)
			regRdData <= next_rdData;
		else
			regRdData <= RST_ZERO;
	end
endmodule // mpt_mac_time
`default_nettype wire

// >>> core/mpt_time_core.sv
// seconds and sub-second counter with coarse or fine advance and offset
// assumed: controls come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module mpt_time_core
	import mpt_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// controls
	input  wire logic             run,
	input  wire logic             fine,
	input  wire logic [31:0]      incr,
	input  wire logic [31:0]      addend,
	// direct loads
	input  wire logic             loadSec,
	input  wire logic             loadSub,
	input  wire logic [31:0]      loadData,
	// offset
	input  wire logic             applyOffset,
	input  wire logic [31:0]      offSec,
	input  wire logic [31:0]      offSub,
	// results
	output mpt_time_s             now,
	output logic                  offsetDone
);
	logic [31:0]      acc;
	logic [32:0]      accSum;
	logic             step;
	logic [31:0]      subAdv;
	logic [31:0]      secAdv;
	logic [31:0]      subOff;
	logic [31:0]      secOff;

	// accumulator for fine mode, carry marks its overflow
	assign accSum = {1'b0, acc} + {1'b0, addend};
	assign step   = run && (!fine || accSum[32]);

	// advance, bit 31 of the sum is a sub-second overflow
	always_comb
	begin
		subAdv = {1'b0, now.sub};
		secAdv = now.sec;
		if (step)
		begin
			subAdv = {1'b0, now.sub} + incr;
			if (subAdv[SUB_W])
				secAdv = now.sec + 32'h00000001;
		end
	end

	// signed offset on top of the advanced time
	always_comb
	begin
		subOff = {1'b0, subAdv[SUB_W-1:0]};
		secOff = secAdv;
		if (offSub[SUB_W])
		begin
			subOff = {1'b0, subAdv[SUB_W-1:0]}
				- {1'b0, offSub[SUB_W-1:0]};
			secOff = secAdv - offSec
				- {31'h00000000, subOff[SUB_W]};
		end
		else
		begin
			subOff = {1'b0, subAdv[SUB_W-1:0]}
				+ {1'b0, offSub[SUB_W-1:0]};
			secOff = secAdv + offSec
				+ {31'h00000000, subOff[SUB_W]};
		end
	end

	// fine accumulator, wraps on overflow
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			acc <= RST_ZERO;
		else if (run && fine)
			acc <= accSum[31:0];
	end

	// time register, direct loads win over counting
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			now        <= '0;
			offsetDone <= 1'b0;
		end
		else
		begin
			offsetDone <= applyOffset;
			if (loadSec || loadSub)
			begin
				now.sec <= loadSec ? loadData : secAdv;
				now.sub <= loadSub ? loadData[SUB_W-1:0]
					: subAdv[SUB_W-1:0];
			end
			else if (applyOffset)
			begin
				now.sec <= secOff;
				now.sub <= subOff[SUB_W-1:0];
			end
			else
			begin
				now.sec <= secAdv;
				now.sub <= subAdv[SUB_W-1:0];
			end
		end
	end
endmodule // mpt_time_core
`default_nettype wire

// >>> include/mpt_pkg.sv
// constants, register map and carriers for the mac time and error block
// assumed: one 40 MHz clock, plain strobe register port, byte offsets
package mpt_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTL    = 8'h00;
	localparam logic [7:0] OFS_INC    = 8'h04;
	localparam logic [7:0] OFS_ADDEND = 8'h08;
	localparam logic [7:0] OFS_SEC    = 8'h0c;
	localparam logic [7:0] OFS_SUB    = 8'h10;
	localparam logic [7:0] OFS_UPDSEC = 8'h14;
	localparam logic [7:0] OFS_UPDSUB = 8'h18;
	localparam logic [7:0] OFS_ALMSEC = 8'h1c;
	localparam logic [7:0] OFS_ALMSUB = 8'h20;
	localparam logic [7:0] OFS_CMD    = 8'h24;
	localparam logic [7:0] OFS_IEN    = 8'h28;
	localparam logic [7:0] OFS_STA    = 8'h2c;
	localparam logic [7:0] OFS_FFT    = 8'h30;
	localparam logic [7:0] OFS_RSDR   = 8'h34;

	// timestamp control fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_START  = 1;
	localparam int CTL_FINE   = 2;
	localparam int CTL_UPDATE = 3;
	localparam int CTL_ALARM  = 5;
	localparam logic [31:0] CTL_MASK = 32'h0000002f;

	// mac command fields
	localparam int CMD_ALP   = 1;
	localparam int CMD_ARP   = 2;
	localparam int CMD_AEP   = 4;
	localparam int CMD_SHARE = 7;
	localparam logic [31:0] CMD_MASK = 32'h00000096;

	// status bit positions, only the alarm bit is kept by the enable register
	localparam int ST_CRC   = 1;
	localparam int ST_RECEIVE_FIFO_OVERFLOW  = 2;
	localparam int ST_LONG  = 3;
	localparam int ST_ALIGN = 5;
	localparam int ST_SHORT = 6;
	localparam int ST_RDU   = 10;
	localparam int ST_RXBUS = 11;
	localparam int ST_TRANSMIT_FIFO_UNAVAILABLE = 17;
	localparam int ST_TRANSMIT_ABORTED = 21;
	localparam int ST_TDU   = 23;
	localparam int ST_TXBUS = 24;
	localparam int ST_ALARM = 28;
	localparam logic [31:0] IEN_MASK = 32'h10000000;

	// fifo threshold fields
	localparam int FFT_RX_LO = 0;
	localparam int FFT_TX_LO = 8;
	localparam logic [31:0] FFT_MASK = 32'h00000303;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h00000000;

	// sub-second count width, bit 31 is the overflow
	localparam int SUB_W = 31;

	// one point in network time
	typedef struct packed {
		logic [31:0]      sec;
		logic [SUB_W-1:0] sub;
	} mpt_time_s;

	// one-cycle error events from the mac datapath
	typedef struct packed {
		logic txBusFault;
		logic txDescExhausted;
		logic txAborted;
		logic txFifoUnavailable;
		logic rxBusFault;
		logic rxDescExhausted;
		logic shortFrame;
		logic alignmentFault;
		logic oversizeFrame;
		logic rxFifoOverflow;
		logic checksumFault;
	} mpt_err_s;

endpackage

// >>> tb/mpt_mac_time_monitor.sv
// checker for the mac time and error block ports
// assumed: bound to mpt_mac_time, one clock, reset active high
`timescale 1ns/1ps
`default_nettype none
module mpt_mac_time_monitor
	import mpt_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register port
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdData,
	// datapath side
	input wire mpt_err_s    errEvents,
	input wire logic        acceptShortFrames,
	input wire logic        acceptOversizeFrames,
	input wire logic        acceptErroredFrames,
	input wire logic [1:0]  transmitFifoThreshold,
	input wire logic [1:0]  receiveFifoThreshold,
	input wire logic        rxHalted,
	input wire logic        receiveStartDemand,
	input wire logic        txIrq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// register writes of interest
	sequence rsdrWr;
		regWr && regAddr == OFS_RSDR;
	endsequence
	sequence cmdWr;
		regWr && regAddr == OFS_CMD;
	endsequence
	sequence fftWr;
		regWr && regAddr == OFS_FFT;
	endsequence

	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside its slot");
	AST_RDU_HALT: assert property (errEvents.rxDescExhausted |=> rxHalted)
		else $error("receive not halted");
	AST_RESUME: assert property (rsdrWr ##0 !errEvents.rxDescExhausted
		|=> !rxHalted && receiveStartDemand)
		else $error("start demand did not resume");
	AST_HALT_HOLD: assert property (rxHalted && !(regWr && regAddr == OFS_RSDR)
		|=> rxHalted)
		else $error("halt dropped without demand");
	AST_DEMAND_CAUSE: assert property (receiveStartDemand
		|-> $past(regWr) && $past(regAddr) == OFS_RSDR)
		else $error("demand without write");
	AST_ACCEPT: assert property (cmdWr |=> ##1
		acceptShortFrames == $past(regWrData[CMD_ARP], 2) &&
		acceptOversizeFrames == $past(regWrData[CMD_ALP], 2) &&
		acceptErroredFrames == $past(regWrData[CMD_AEP], 2))
		else $error("accept controls wrong");
	AST_FIFO_THR: assert property (fftWr |=> ##1
		transmitFifoThreshold == $past(regWrData[9:8], 2) &&
		receiveFifoThreshold == $past(regWrData[1:0], 2))
		else $error("fifo thresholds wrong");
	AST_IRQ_FALL: assert property ($fell(txIrq)
		|-> $past(regWr) || $past(regWr, 2) || $past(regWr, 3))
		else $error("interrupt dropped by itself");
endmodule // mpt_mac_time_monitor

bind mpt_mac_time mpt_mac_time_monitor u_mon (
	.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .errEvents(errEvents),
	.acceptShortFrames(acceptShortFrames),
	.acceptOversizeFrames(acceptOversizeFrames),
	.acceptErroredFrames(acceptErroredFrames),
	.transmitFifoThreshold(transmitFifoThreshold),
	.receiveFifoThreshold(receiveFifoThreshold),
	.rxHalted(rxHalted), .receiveStartDemand(receiveStartDemand),
	.txIrq(txIrq));
`default_nettype wire

// >>> tb/mpt_mac_time_tb_top.sv
// self-checking bench for the mac time and error block
// assumed: package, design and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module mpt_mac_time_tb_top
	import mpt_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData, rv;
	logic        regWr, regRd, accShort, accLong, accErr;
	logic [1:0]  txThr, rxThr;
	logic        rxHalt, startDem, txIrq;
	mpt_time_s   peerTime, ownTime, curTime;
	mpt_err_s    errEvents;
	logic [62:0] t0;
	int          fail_count = 0;
	int          n_tests = 0;
	int          k;
	int          sb[11] = '{1, 2, 3, 5, 6, 10, 11, 17, 21, 23, 24};

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	mpt_mac_time uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .peerTime(peerTime), .ownTime(ownTime),
		.currentTime(curTime), .errEvents(errEvents),
		.acceptShortFrames(accShort), .acceptOversizeFrames(accLong),
		.acceptErroredFrames(accErr), .transmitFifoThreshold(txThr),
		.receiveFifoThreshold(rxThr), .rxHalted(rxHalt),
		.receiveStartDemand(startDem), .txIrq(txIrq));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 rv = regRdData;
		chk(rv, e);
	endtask

	// wait edges, then let their updates land
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse(input mpt_err_s e);
		@(posedge ref_clk);
		errEvents <= e;
		@(posedge ref_clk);
		errEvents <= '0;
	endtask

	task automatic wrap_up;
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		wrap_up;
	end

	// main sequence
	initial
	begin
		rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = '0;
		regWrData = '0;
		peerTime = '0;
		errEvents = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(OFS_CTL, 32'h0);
		rdc(OFS_STA, 32'h0);
		wr(8'h3c, 32'hffffffff);
		rdc(8'h3c, 32'h0);
		// values first, then start; start without enable holds
		wr(OFS_SEC, 32'h5);
		wr(OFS_SUB, 32'h7fffff00);
		wr(OFS_INC, 32'h10);
		wr(OFS_CTL, 32'h2);
		settle(1);
		t0 = ownTime;
		settle(4);
		chk(ownTime, t0);
		wr(OFS_CTL, 32'h1);
		settle(4);
		chk(ownTime, t0);
		// coarse step across the overflow
		wr(OFS_CTL, 32'h3);
		settle(2);
		t0 = ownTime;
		for (k = 0; k < 20; k++)
		begin
			settle(1);
			chk(ownTime, t0 + 63'h10);
			t0 = ownTime;
		end
		chk(t0[62:31], 32'h6);
		// fine: carry every fourth clock
		wr(OFS_ADDEND, 32'h40000000);
		wr(OFS_INC, 32'h100);
		wr(OFS_CTL, 32'h7);
		settle(2);
		t0 = ownTime;
		settle(16);
		chk(ownTime, t0 + 63'h400);
		// seconds held from the sub-second read, counter stopped
		wr(OFS_CTL, 32'h1);
		wr(OFS_SEC, 32'h33);
		wr(OFS_SUB, 32'h1234);
		settle(2);
		rdc(OFS_SUB, 32'h1234);
		wr(OFS_SEC, 32'h44);
		settle(2);
		rdc(OFS_SEC, 32'h33);
		chk(curTime.sec, 32'h44);
		rdc(OFS_SUB, 32'h1234);
		rdc(OFS_SEC, 32'h44);
		// signed offsets with borrow and carry
		wr(OFS_CTL, 32'h1);
		wr(OFS_SEC, 32'd10);
		wr(OFS_SUB, 32'h100);
		wr(OFS_UPDSEC, 32'd2);
		wr(OFS_UPDSUB, 32'h80000200);
		wr(OFS_CTL, 32'h9);
		settle(4);
		chk(ownTime, {32'd7, 31'h7fffff00});
		rdc(OFS_CTL, 32'h1);
		wr(OFS_UPDSEC, 32'd1);
		wr(OFS_UPDSUB, 32'h7fffff00);
		wr(OFS_CTL, 32'h9);
		settle(4);
		chk(ownTime, {32'd9, 31'h7ffffe00});
		// alarm: off, not reached, reached, masked, cleared
		wr(OFS_ALMSEC, 32'd9);
		wr(OFS_ALMSUB, 32'h7ffffe00);
		wr(OFS_IEN, 32'h10000000);
		settle(4);
		rdc(OFS_STA, 32'h0);
		wr(OFS_ALMSUB, 32'h7ffffe01);
		wr(OFS_CTL, 32'h21);
		settle(4);
		rdc(OFS_STA, 32'h0);
		wr(OFS_ALMSUB, 32'h7ffffe00);
		settle(4);
		rdc(OFS_STA, 32'h10000000);
		chk(txIrq, 1'b1);
		wr(OFS_IEN, 32'h0);
		settle(3);
		chk(txIrq, 1'b0);
		wr(OFS_IEN, 32'h10000000);
		wr(OFS_STA, 32'h10000000);
		settle(6);
		chk(txIrq, 1'b0);
		rdc(OFS_STA, 32'h0);
		// error flags, one event at a time
		wr(OFS_CMD, 32'h16);
		wr(OFS_FFT, 32'h302);
		settle(2);
		chk({accShort, accLong, accErr, txThr, rxThr}, 7'h7e);
		for (k = 0; k < 11; k++)
		begin
			pulse(mpt_err_s'(11'h1 << k));
			settle(2);
			rdc(OFS_STA, 32'h1 << sb[k]);
			wr(OFS_STA, 32'hffffffff);
			rdc(OFS_STA, 32'h0);
		end
		chk(rxHalt, 1'b1);
		wr(OFS_RSDR, 32'h0);
		settle(1);
		chk(rxHalt, 1'b0);
		// short and long frames without acceptance
		wr(OFS_CMD, 32'h0);
		pulse(mpt_err_s'(11'h014));
		settle(2);
		rdc(OFS_STA, 32'h0);
		// borrowed time source
		peerTime <= {32'h55, 31'h1234};
		wr(OFS_CMD, 32'h80);
		settle(3);
		chk(curTime, {32'h55, 31'h1234});
		chk(ownTime, {32'd9, 31'h7ffffe00});
		wr(OFS_CMD, 32'h0);
		settle(3);
		chk(curTime, {32'd9, 31'h7ffffe00});
		wrap_up;
	end
endmodule // mpt_mac_time_tb_top
`default_nettype wire
